// *** control_subcommand_decoder.sv ***
// Control subcommand decoder with status word, access lock and mode flags
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Control write carries a two-byte subcommand
// - 0x0000 returns the control status word
// - 0x0001 device type, 0x0002 firmware revision
// - 0x0004 returns configuration code
// - 0x0007 returns previous subcommand below 0x0015
// - 0x0008 returns chemistry profile identifier
// - 0x000C/0x000D force cell presence when detect off
// - 0x0011/0x0012 set/clear deep-sleep request
// - 0x0013 enters config edit when unlocked
// - 0x001B arms power-off, status bit 15
// - 0x001C powers off when unlocked
// - 0x0020 locks access
// - 0x0023 pulses output pin 1 ms
// - 0x0041 full reset when unlocked
// - 0x0042 soft reset leaves config edit
// - 0x0043 leaves edit, no measurement or resim
// - 0x0044 leaves edit then resimulates
// - Locked accepts only 0x0000-0x0012 and 0x0023
// - High byte flags watchdog, lock, calibrations
// - Learned bits clear on reset/insertion; ordered
// - Counter autocal after 3m45s, then periodic
// - Low byte flags init, sleep, model, voltage
// - Power-off needs prior arm command
// - Soft reset/resim exit clear flags, resimulate
// - Deep-sleep request clears on deep-sleep exit
module control_subcommand_decoder #(
  parameter logic [16:0] GENERAL_OUTPUT_PIN_PULSE_CYCLES = gauge_ctrl_pkg::GENERAL_OUTPUT_PIN_PULSE_CYCLES,
  parameter logic [34:0] AUTOCAL_DELAY_CYCLES = gauge_ctrl_pkg::AUTOCAL_DELAY_CYCLES,
  parameter logic [34:0] AUTOCAL_PERIOD_CYCLES = gauge_ctrl_pkg::AUTOCAL_PERIOD_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire gauge_ctrl_pkg::cmd_port_t cmd,
  input wire gauge_ctrl_pkg::gauge_state_t gauge,
  input wire gauge_ctrl_pkg::gauge_ids_t ids,
  output logic [7:0] cmdRdData,
  output logic cmdRdValid,
  output logic cellPresentFlag,
  output logic configEditFlag,
  output logic initPendingFlag,
  output logic lockedState,
  output logic powerOffArmed,
  output logic shutdownReq,
  output logic fullResetReq,
  output logic ocvMeasureReq,
  output logic resimReq,
  output logic generalOutputPin
);

  logic subValid;
  logic [15:0] subCode;
  logic lockedOk;
  logic accepted;
  logic [15:0] statusWord;
  logic [15:0] result_reg;
  logic statusLive_reg;
  logic [15:0] lastCmd_reg;
  logic deepSleepReq_reg;
  logic capLearned_reg;
  logic resLearned_reg;
  logic constPower_reg;
  logic cellPresent_next;
  logic cellInsertEvent;
  logic gpoutStart;
  logic gpoutDone;
  logic isAccepted;
  gauge_ctrl_pkg::acal_state_t acalState_reg;
  gauge_ctrl_pkg::acal_state_t acalState_next;
  logic acalKick_reg;
  logic acalFirst_reg;
  logic acalStart;
  logic acalDone;
  logic [34:0] acalLength;

  subcommand_capture capture (
    .clk(clk),
    .reset(reset),
    .clkEn(clkEn),
    .cmd(cmd),
    .subValid(subValid),
    .subCode(subCode)
  );

  // Locked state admits only the read-type and harmless codes
  assign lockedOk = (subCode <= gauge_ctrl_pkg::CMD_DEEP_SLEEP_CLEAR)
    || (subCode == gauge_ctrl_pkg::CMD_PULSE_OUTPUT_PIN);
  assign accepted = subValid && (!lockedState || lockedOk);
  assign isAccepted = accepted;

  assign statusWord = {
    powerOffArmed, gauge.watchdogEvent, lockedState, gauge.calibrationActive,
    acalState_reg == gauge_ctrl_pkg::ACAL_RUN, gauge.boardCal,
    capLearned_reg, resLearned_reg,
    gauge.initDone, deepSleepReq_reg, 1'b0, gauge.sleepMode,
    constPower_reg, gauge.tableBlock, gauge.voltageValid, 1'b0
  };

  // Cell presence: host commands rule only while pin detection is off
  always_comb begin
    cellPresent_next = cellPresentFlag;
    if (gauge.insertionDetectEnable) begin
      cellPresent_next = gauge.cellDetectPin;
    end else if (accepted && subCode == gauge_ctrl_pkg::CMD_FORCE_CELL_PRESENT) begin
      cellPresent_next = 1'b1;
    end else if (accepted && subCode == gauge_ctrl_pkg::CMD_FORCE_CELL_ABSENT) begin
      cellPresent_next = 1'b0;
    end
  end
  assign cellInsertEvent = cellPresent_next && !cellPresentFlag;

  always_ff @(posedge clk) begin
    if (reset) begin
      cellPresentFlag <= 1'b0;
      constPower_reg <= gauge_ctrl_pkg::CONST_POWER_RESET;
    end else if (clkEn) begin
      cellPresentFlag <= cellPresent_next;
      constPower_reg <= gauge.constPower;
    end
  end

  // Learned bits: insertion clears both, resistance waits for capacity
  always_ff @(posedge clk) begin
    if (reset) begin
      capLearned_reg <= 1'b0;
      resLearned_reg <= 1'b0;
    end else if (clkEn) begin
      if (cellInsertEvent) begin
        capLearned_reg <= 1'b0;
        resLearned_reg <= 1'b0;
      end else begin
        if (gauge.capLearnedEvent) begin
          capLearned_reg <= 1'b1;
        end
        if (gauge.resLearnedEvent && capLearned_reg) begin
          resLearned_reg <= 1'b1;
        end
      end
    end
  end

  // Deep-sleep request; a host set in the exit cycle wins
  always_ff @(posedge clk) begin
    if (reset) begin
      deepSleepReq_reg <= 1'b0;
    end else if (clkEn) begin
      if (accepted && subCode == gauge_ctrl_pkg::CMD_DEEP_SLEEP_SET) begin
        deepSleepReq_reg <= 1'b1;
      end else if (accepted && subCode == gauge_ctrl_pkg::CMD_DEEP_SLEEP_CLEAR) begin
        deepSleepReq_reg <= 1'b0;
      end else if (gauge.deepSleepExit) begin
        deepSleepReq_reg <= 1'b0;
      end
    end
  end

  // Mode flags, lock, power-off and reset requests
  always_ff @(posedge clk) begin
    if (reset) begin
      configEditFlag <= 1'b0;
      initPendingFlag <= gauge_ctrl_pkg::INIT_PENDING_RESET;
      lockedState <= 1'b0;
      powerOffArmed <= 1'b0;
      shutdownReq <= 1'b0;
      fullResetReq <= 1'b0;
      ocvMeasureReq <= 1'b0;
      resimReq <= 1'b0;
    end else if (clkEn) begin
      fullResetReq <= 1'b0;
      ocvMeasureReq <= 1'b0;
      resimReq <= 1'b0;
      if (accepted) begin
        case (subCode)
          gauge_ctrl_pkg::CMD_ENTER_CONFIG_EDIT: configEditFlag <= 1'b1;
          gauge_ctrl_pkg::CMD_POWER_OFF_ARM: powerOffArmed <= 1'b1;
          gauge_ctrl_pkg::CMD_POWER_OFF: begin
            if (powerOffArmed) begin
              shutdownReq <= 1'b1;
            end
          end
          gauge_ctrl_pkg::CMD_LOCK_ACCESS: lockedState <= 1'b1;
          gauge_ctrl_pkg::CMD_FULL_RESET: begin
            fullResetReq <= 1'b1;
            initPendingFlag <= 1'b1;
          end
          gauge_ctrl_pkg::CMD_SOFT_RESET: begin
            configEditFlag <= 1'b0;
            initPendingFlag <= 1'b0;
            ocvMeasureReq <= 1'b1;
            resimReq <= 1'b1;
          end
          gauge_ctrl_pkg::CMD_LEAVE_EDIT_PLAIN: begin
            configEditFlag <= 1'b0;
            initPendingFlag <= 1'b0;
          end
          gauge_ctrl_pkg::CMD_LEAVE_EDIT_RESIM: begin
            configEditFlag <= 1'b0;
            initPendingFlag <= 1'b0;
            resimReq <= 1'b1;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Query answers; status stays live so later reads see current bits
  always_ff @(posedge clk) begin
    if (reset) begin
      result_reg <= gauge_ctrl_pkg::RESULT_RESET;
      statusLive_reg <= 1'b1;
      lastCmd_reg <= gauge_ctrl_pkg::RESULT_RESET;
    end else if (clkEn && subValid) begin
      if (subCode < gauge_ctrl_pkg::LAST_CMD_LIMIT) begin
        lastCmd_reg <= subCode;
      end
      if (accepted) begin
        case (subCode)
          gauge_ctrl_pkg::CMD_STATUS_QUERY: statusLive_reg <= 1'b1;
          gauge_ctrl_pkg::CMD_TYPE_QUERY: begin
            statusLive_reg <= 1'b0;
            result_reg <= gauge_ctrl_pkg::DEVICE_TYPE_CODE;
          end
          gauge_ctrl_pkg::CMD_FW_REV_QUERY: begin
            statusLive_reg <= 1'b0;
            result_reg <= ids.fwRev;
          end
          gauge_ctrl_pkg::CMD_CONFIG_CODE_QUERY: begin
            statusLive_reg <= 1'b0;
            result_reg <= {8'h00, ids.configCode};
          end
          gauge_ctrl_pkg::CMD_LAST_CMD_QUERY: begin
            statusLive_reg <= 1'b0;
            result_reg <= lastCmd_reg;
          end
          gauge_ctrl_pkg::CMD_CHEMISTRY_QUERY: begin
            statusLive_reg <= 1'b0;
            result_reg <= ids.chemistryId;
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cmdRdData <= 8'h00;
      cmdRdValid <= 1'b0;
    end else if (clkEn) begin
      cmdRdValid <= cmd.read;
      if (cmd.read && cmd.addr == gauge_ctrl_pkg::CTRL_ADDR_LO) begin
        cmdRdData <= statusLive_reg ? statusWord[7:0] : result_reg[7:0];
      end else if (cmd.read && cmd.addr == gauge_ctrl_pkg::CTRL_ADDR_HI) begin
        cmdRdData <= statusLive_reg ? statusWord[15:8] : result_reg[15:8];
      end else begin
        cmdRdData <= 8'h00;
      end
    end
  end

  // Output pin pulse; a repeat while busy restarts the full 1 ms
  assign gpoutStart = isAccepted && subCode == gauge_ctrl_pkg::CMD_PULSE_OUTPUT_PIN;

  interval_timer #(
    .WIDTH(gauge_ctrl_pkg::GENERAL_OUTPUT_PIN_TIMER_W)
  ) gpoutTimer (
    .clk(clk),
    .reset(reset),
    .clkEn(clkEn),
    .start(gpoutStart),
    .length(GENERAL_OUTPUT_PIN_PULSE_CYCLES),
    .busy(generalOutputPin),
    .done(gpoutDone)
  );

  // Counter autocal: one timer alternates wait and run intervals
  assign acalState_next = acalDone
    ? (acalState_reg == gauge_ctrl_pkg::ACAL_WAIT ? gauge_ctrl_pkg::ACAL_RUN
                                                  : gauge_ctrl_pkg::ACAL_WAIT)
    : acalState_reg;
  assign acalStart = acalKick_reg || acalDone;
  assign acalLength = (acalState_next == gauge_ctrl_pkg::ACAL_RUN)
    ? gauge_ctrl_pkg::AUTOCAL_RUN_CYCLES
    : (acalFirst_reg ? AUTOCAL_DELAY_CYCLES : AUTOCAL_PERIOD_CYCLES);

  always_ff @(posedge clk) begin
    if (reset) begin
      acalState_reg <= gauge_ctrl_pkg::ACAL_WAIT;
      acalKick_reg <= 1'b1;
      acalFirst_reg <= 1'b1;
    end else if (clkEn) begin
      if (fullResetReq) begin
        // Reinitialisation restarts the first delay
        acalState_reg <= gauge_ctrl_pkg::ACAL_WAIT;
        acalKick_reg <= 1'b1;
        acalFirst_reg <= 1'b1;
      end else begin
        acalKick_reg <= 1'b0;
        acalState_reg <= acalState_next;
        if (acalDone && acalState_reg == gauge_ctrl_pkg::ACAL_WAIT) begin
          acalFirst_reg <= 1'b0;
        end
      end
    end
  end

  interval_timer #(
    .WIDTH(gauge_ctrl_pkg::ACAL_TIMER_W)
  ) acalTimer (
    .clk(clk),
    .reset(reset),
    .clkEn(clkEn),
    .start(acalStart),
    .length(acalLength),
    .busy(),
    .done(acalDone)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  lock_takes_a: assert property (clkEn && accepted
    && subCode == gauge_ctrl_pkg::CMD_LOCK_ACCESS |=> lockedState)
    else $error("lock command did not lock");
  locked_refuse_a: assert property (clkEn && subValid && lockedState && !configEditFlag
    && subCode == gauge_ctrl_pkg::CMD_ENTER_CONFIG_EDIT |=> !configEditFlag)
    else $error("locked device entered config edit");
  arm_bit_a: assert property (clkEn && subValid && !lockedState
    && subCode == gauge_ctrl_pkg::CMD_POWER_OFF_ARM |=> statusWord[15])
    else $error("arm command did not set status bit 15");
  power_off_arm_a: assert property ($rose(shutdownReq) |-> $past(powerOffArmed))
    else $error("power-off without prior arm");
  deep_sleep_set_a: assert property (clkEn && subValid
    && subCode == gauge_ctrl_pkg::CMD_DEEP_SLEEP_SET |=> statusWord[6])
    else $error("deep-sleep request not set");
  cell_force_a: assert property (clkEn && subValid && !gauge.insertionDetectEnable
    && subCode == gauge_ctrl_pkg::CMD_FORCE_CELL_PRESENT |=> cellPresentFlag)
    else $error("cell present not forced");
  resim_exit_a: assert property (clkEn && subValid && !lockedState
    && subCode == gauge_ctrl_pkg::CMD_LEAVE_EDIT_RESIM
    |=> !configEditFlag && !initPendingFlag && resimReq)
    else $error("resim exit did not clear flags and resimulate");
  learn_order_a: assert property (resLearned_reg |-> capLearned_reg)
    else $error("resistance learned before capacity");
  general_output_pin_width_a: assert property ($rose(generalOutputPin) |-> generalOutputPin [*8])
    else $error("output pin pulse too short");
  type_answer_a: assert property (clkEn && subValid
    && subCode == gauge_ctrl_pkg::CMD_TYPE_QUERY
    |=> result_reg == gauge_ctrl_pkg::DEVICE_TYPE_CODE && !statusLive_reg)
    else $error("device type not returned");

  lock_seen_c: cover property ($rose(lockedState));
  power_off_c: cover property ($rose(shutdownReq));
  general_output_pin_pulse_c: cover property ($fell(generalOutputPin));
  resim_c: cover property (resimReq);

endmodule
`default_nettype wire

// *** gauge_ctrl_pkg.sv ***
// Constants, codes and carrier types shared by the control subcommand decoder
package gauge_ctrl_pkg;

  localparam longint unsigned CLK_HZ = 125_000_000;

  // Command-code addresses of the control word
  localparam logic [7:0] CTRL_ADDR_LO = 8'h00;
  localparam logic [7:0] CTRL_ADDR_HI = 8'h01;

  // Subcommand codes
  localparam logic [15:0] CMD_STATUS_QUERY = 16'h0000;
  localparam logic [15:0] CMD_TYPE_QUERY = 16'h0001;
  localparam logic [15:0] CMD_FW_REV_QUERY = 16'h0002;
  localparam logic [15:0] CMD_CONFIG_CODE_QUERY = 16'h0004;
  localparam logic [15:0] CMD_LAST_CMD_QUERY = 16'h0007;
  localparam logic [15:0] CMD_CHEMISTRY_QUERY = 16'h0008;
  localparam logic [15:0] CMD_FORCE_CELL_PRESENT = 16'h000C;
  localparam logic [15:0] CMD_FORCE_CELL_ABSENT = 16'h000D;
  localparam logic [15:0] CMD_DEEP_SLEEP_SET = 16'h0011;
  localparam logic [15:0] CMD_DEEP_SLEEP_CLEAR = 16'h0012;
  localparam logic [15:0] CMD_ENTER_CONFIG_EDIT = 16'h0013;
  localparam logic [15:0] CMD_POWER_OFF_ARM = 16'h001B;
  localparam logic [15:0] CMD_POWER_OFF = 16'h001C;
  localparam logic [15:0] CMD_LOCK_ACCESS = 16'h0020;
  localparam logic [15:0] CMD_PULSE_OUTPUT_PIN = 16'h0023;
  localparam logic [15:0] CMD_FULL_RESET = 16'h0041;
  localparam logic [15:0] CMD_SOFT_RESET = 16'h0042;
  localparam logic [15:0] CMD_LEAVE_EDIT_PLAIN = 16'h0043;
  localparam logic [15:0] CMD_LEAVE_EDIT_RESIM = 16'h0044;
  // Codes at or above this are not kept as the last command
  localparam logic [15:0] LAST_CMD_LIMIT = 16'h0015;

  // Arbitrary identification value, not tied to any real part
  localparam logic [15:0] DEVICE_TYPE_CODE = 16'h5A3C;

  // Status word bit positions
  localparam int unsigned ST_POWER_OFF_ARMED = 15;
  localparam int unsigned ST_WATCHDOG_EVENT = 14;
  localparam int unsigned ST_LOCKED = 13;
  localparam int unsigned ST_CALIBRATION = 12;
  localparam int unsigned ST_COUNTER_AUTOCAL = 11;
  localparam int unsigned ST_BOARD_CAL = 10;
  localparam int unsigned ST_CAP_LEARNED = 9;
  localparam int unsigned ST_RES_LEARNED = 8;
  localparam int unsigned ST_INIT_DONE = 7;
  localparam int unsigned ST_DEEP_SLEEP_REQ = 6;
  localparam int unsigned ST_SLEEP = 4;
  localparam int unsigned ST_CONST_POWER = 3;
  localparam int unsigned ST_TABLE_BLOCK = 2;
  localparam int unsigned ST_VOLTAGE_VALID = 1;

  // Values after reset
  localparam logic CONST_POWER_RESET = 1'b1;
  localparam logic INIT_PENDING_RESET = 1'b1;
  localparam logic [15:0] RESULT_RESET = 16'h0000;

  // Timing
  localparam int unsigned GENERAL_OUTPUT_PIN_TIMER_W = 17;
  localparam int unsigned GENERAL_OUTPUT_PIN_PULSE_MS = 1;
  localparam logic [GENERAL_OUTPUT_PIN_TIMER_W-1:0] GENERAL_OUTPUT_PIN_PULSE_CYCLES =
    GENERAL_OUTPUT_PIN_TIMER_W'(GENERAL_OUTPUT_PIN_PULSE_MS * CLK_HZ / 1000);
  localparam int unsigned ACAL_TIMER_W = 35;
  localparam int unsigned AUTOCAL_DELAY_MIN = 3;
  localparam int unsigned AUTOCAL_DELAY_SEC = 45;
  localparam logic [ACAL_TIMER_W-1:0] AUTOCAL_DELAY_CYCLES =
    ACAL_TIMER_W'((AUTOCAL_DELAY_MIN * 60 + AUTOCAL_DELAY_SEC) * CLK_HZ);
  localparam logic [ACAL_TIMER_W-1:0] AUTOCAL_PERIOD_CYCLES = AUTOCAL_DELAY_CYCLES;
  localparam logic [ACAL_TIMER_W-1:0] AUTOCAL_RUN_CYCLES = 35'h3E8;

  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [7:0] data;
  } cmd_port_t;

  typedef struct packed {
    logic watchdogEvent;
    logic calibrationActive;
    logic boardCal;
    logic sleepMode;
    logic initDone;
    logic constPower;
    logic tableBlock;
    logic voltageValid;
    logic capLearnedEvent;
    logic resLearnedEvent;
    logic deepSleepExit;
    logic insertionDetectEnable;
    logic cellDetectPin;
  } gauge_state_t;

  typedef struct packed {
    logic [15:0] fwRev;
    logic [15:0] chemistryId;
    logic [7:0] configCode;
  } gauge_ids_t;

  typedef enum logic [0:0] {
    ACAL_WAIT = 1'b0,
    ACAL_RUN = 1'b1
  } acal_state_t;

endpackage

// *** host_model.sv ***
// Host model that sends control subcommands and reads back the control word
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input wire logic clk,
  input wire logic [7:0] cmdRdData,
  input wire logic cmdRdValid,
  output var gauge_ctrl_pkg::cmd_port_t cmd
);
  initial cmd = '0;

  // Low byte first, then high byte, one strobe per byte
  task automatic wr16(input logic [15:0] code);
    @(negedge clk);
    cmd = '{1'b1, 1'b0, gauge_ctrl_pkg::CTRL_ADDR_LO, code[7:0]};
    @(negedge clk);
    cmd = '{1'b1, 1'b0, gauge_ctrl_pkg::CTRL_ADDR_HI, code[15:8]};
    @(negedge clk);
    // Idle bus shows a changed pattern so stale data cannot pass for a write
    cmd = '{1'b0, 1'b0, 8'hA5, ~code[15:8]};
  endtask

  task automatic rd16(output logic [15:0] word, output logic ok);
    logic [7:0] b [2];
    int k;
    ok = 1'b1;
    for (int i = 0; i < 2; i++) begin
      @(negedge clk);
      cmd = '{1'b0, 1'b1, 8'(i), ~cmd.data};
      @(negedge clk);
      cmd.read = 1'b0;
      for (k = 0; k < 3 && cmdRdValid !== 1'b1; k++) @(negedge clk);
      ok &= (cmdRdValid === 1'b1);
      b[i] = cmdRdData;
    end
    word = {b[1], b[0]};
  endtask
endmodule
`default_nettype wire

// *** interval_timer.sv ***
// One-shot interval timer: busy for length cycles, then a done pulse
`timescale 1ns/1ns
`default_nettype none
module interval_timer #(
  parameter int unsigned WIDTH = 17
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic start,
  input wire logic [WIDTH-1:0] length,
  output logic busy,
  output logic done
);

  logic [WIDTH-1:0] count_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      count_reg <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (clkEn) begin
      done <= 1'b0;
      if (start) begin
        count_reg <= length - WIDTH'(1);
        busy <= 1'b1;
      end else if (busy) begin
        if (count_reg == '0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count_reg <= count_reg - WIDTH'(1);
        end
      end
    end
  end

endmodule
`default_nettype wire

// *** subcommand_capture.sv ***
// Pairs the two control-word bytes into one subcommand strobe
`timescale 1ns/1ns
`default_nettype none
module subcommand_capture (
  input wire logic clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire gauge_ctrl_pkg::cmd_port_t cmd,
  output logic subValid,
  output logic [15:0] subCode
);

  logic [7:0] lowByte_reg;
  logic lowPending_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      lowByte_reg <= 8'h00;
      lowPending_reg <= 1'b0;
      subValid <= 1'b0;
      subCode <= 16'h0000;
    end else if (clkEn) begin
      subValid <= 1'b0;
      if (cmd.write && cmd.addr == gauge_ctrl_pkg::CTRL_ADDR_LO) begin
        lowByte_reg <= cmd.data;
        lowPending_reg <= 1'b1;
      end else if (cmd.write && cmd.addr == gauge_ctrl_pkg::CTRL_ADDR_HI && lowPending_reg) begin
        // A high byte with no low byte before it is dropped
        subValid <= 1'b1;
        subCode <= {cmd.data, lowByte_reg};
        lowPending_reg <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the control subcommand decoder
`timescale 1ns/1ns
`default_nettype none
module testbench;
  typedef logic [15:0] code_q_t[$];
  localparam logic [16:0] PULSE = 17'h14;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic clkEn = 1'b1;
  gauge_ctrl_pkg::cmd_port_t cmd;
  gauge_ctrl_pkg::gauge_state_t gauge = 13'h0080;
  gauge_ctrl_pkg::gauge_ids_t ids = '0;
  logic [7:0] cmdRdData;
  logic cmdRdValid, cellPresentFlag, configEditFlag, initPendingFlag, lockedState;
  logic powerOffArmed, shutdownReq, fullResetReq, ocvMeasureReq, resimReq, pinOut;
  int n_fail = 0;
  int n_compared = 0;
  int cycles = 0;
  int seed = 32'h1B92;
  bit mLock, mArm, mEdit, mInit, mCell, mSlp, mShut, mCap, mRes, mAcalIdle;
  int mLast, mSel, cOcv, cRes, cFull, cPin, eOcv, eRes, eFull, ePin;

  always #4 clk = ~clk;

  host_model host_model_inst (.clk(clk), .cmdRdData(cmdRdData), .cmdRdValid(cmdRdValid),
    .cmd(cmd));

  control_subcommand_decoder #(.GENERAL_OUTPUT_PIN_PULSE_CYCLES(PULSE), .AUTOCAL_DELAY_CYCLES(35'h32),
    .AUTOCAL_PERIOD_CYCLES(35'h28)) control_subcommand_decoder_inst (
    .clk(clk), .reset(reset), .clkEn(clkEn), .cmd(cmd), .gauge(gauge), .ids(ids),
    .cmdRdData(cmdRdData), .cmdRdValid(cmdRdValid), .cellPresentFlag(cellPresentFlag),
    .configEditFlag(configEditFlag), .initPendingFlag(initPendingFlag),
    .lockedState(lockedState), .powerOffArmed(powerOffArmed), .shutdownReq(shutdownReq),
    .fullResetReq(fullResetReq), .ocvMeasureReq(ocvMeasureReq), .resimReq(resimReq),
    .generalOutputPin(pinOut));

  always @(posedge clk) begin
    cycles++;
    cOcv += ocvMeasureReq;
    cRes += resimReq;
    cFull += fullResetReq;
    cPin += pinOut;
    if (cycles == 6000) begin
      n_fail++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [15:0] statusExp();
    return {mArm, gauge.watchdogEvent, mLock, gauge.calibrationActive, 1'b0, gauge.boardCal,
      mCap, mRes, gauge.initDone, mSlp, 1'b0, gauge.sleepMode, gauge.constPower,
      gauge.tableBlock, gauge.voltageValid, 1'b0};
  endfunction

  // Autocal bit is only known low in the first delay after reset; later its phase is masked
  task automatic verify();
    logic [15:0] w;
    logic [15:0] m;
    logic [15:0] e;
    logic ok;
    repeat (3) @(negedge clk);
    host_model_inst.rd16(w, ok);
    m = mAcalIdle ? 16'hFFFF : 16'hF7FF;
    e = (mSel < 0) ? statusExp() : 16'(mSel);
    mAcalIdle = 1'b0;
    check("read valid", ok, 1'b1);
    check("control word", w & m, e & m);
    check("cell flag", cellPresentFlag, mCell);
    check("edit flag", configEditFlag, mEdit);
    check("init flag", initPendingFlag, mInit);
    check("locked", lockedState, mLock);
    check("armed", powerOffArmed, mArm);
    check("shutdown", shutdownReq, mShut);
    check("ocv pulses", 16'(cOcv), 16'(eOcv));
    check("resim pulses", 16'(cRes), 16'(eRes));
    check("reset pulses", 16'(cFull), 16'(eFull));
    check("pin cycles", 16'(cPin), 16'(ePin));
  endtask

  task automatic issue(input logic [15:0] c);
    int prev;
    prev = mLast;
    gauge[12:5] = 8'($random(seed));
    host_model_inst.wr16(c);
    if (c < 16'h0015) mLast = c;
    case (c)
      16'h0000: mSel = -1;
      16'h0001: mSel = gauge_ctrl_pkg::DEVICE_TYPE_CODE;
      16'h0002: mSel = ids.fwRev;
      16'h0004: mSel = ids.configCode;
      16'h0007: mSel = prev;
      16'h0008: mSel = ids.chemistryId;
      16'h000C: if (!gauge.insertionDetectEnable) begin
        if (!mCell) {mCap, mRes} = 2'b00;
        mCell = 1'b1;
      end
      16'h000D: if (!gauge.insertionDetectEnable) mCell = 1'b0;
      16'h0011: mSlp = 1'b1;
      16'h0012: mSlp = 1'b0;
      16'h0013: if (!mLock) mEdit = 1'b1;
      16'h001B: if (!mLock) mArm = 1'b1;
      16'h001C: if (!mLock && mArm) mShut = 1'b1;
      16'h0020: mLock = 1'b1;
      16'h0023: ePin += PULSE;
      16'h0041: if (!mLock) begin
        mInit = 1'b1;
        eFull++;
      end
      16'h0042: if (!mLock) begin
        {mInit, mEdit} = 2'b00;
        eOcv++;
        eRes++;
      end
      16'h0043: if (!mLock) {mInit, mEdit} = 2'b00;
      16'h0044: if (!mLock) begin
        {mInit, mEdit} = 2'b00;
        eRes++;
      end
      default: ;
    endcase
    if (c == 16'h0023) repeat (25) @(negedge clk);
    verify();
  endtask

  task automatic run(input string name, input code_q_t list);
    foreach (list[i]) issue(list[i]);
    $display("test %s done", name);
  endtask

  // Gauge-side event pulse: 4 capacity learned, 3 resistance learned, 2 deep-sleep exit
  task automatic pulse(input int b);
    @(negedge clk);
    gauge[b] = 1'b1;
    @(negedge clk);
    gauge[b] = 1'b0;
    if (b == 4) mCap = 1'b1;
    if (b == 3) mRes = mRes | mCap;
    if (b == 2) mSlp = 1'b0;
    verify();
  endtask

  task automatic doReset();
    @(negedge clk);
    reset = 1'b1;
    repeat (4) @(negedge clk);
    reset = 1'b0;
    {mLock, mArm, mEdit, mCell, mSlp, mShut, mCap, mRes} = '0;
    mInit = 1'b1;
    mAcalIdle = 1'b1;
    mSel = -1;
    mLast = 0;
  endtask

  initial begin
    ids = 40'({$random(seed), $random(seed)});
    doReset();
    verify();
    $display("test reset values done");
    run("queries", '{16'h0007, 16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h0003, 16'h0015,
      16'h0007, 16'h0000});
    run("sleep request", '{16'h0011});
    pulse(2);
    run("sleep toggle", '{16'h0011, 16'h0012, 16'h0011});
    pulse(3);
    run("cell insert", '{16'h000C});
    pulse(3);
    pulse(4);
    pulse(3);
    run("cell cycle", '{16'h000D, 16'h000C, 16'h000D, 16'h000C});
    gauge.insertionDetectEnable = 1'b1;
    mCell = 1'b0;
    run("detect enabled", '{16'h000D, 16'h000C});
    gauge.insertionDetectEnable = 1'b0;
    run("config edit", '{16'h0013, 16'h0043, 16'h0013, 16'h0042, 16'h0013, 16'h0044,
      16'h0041, 16'h0023});
    clkEn = 1'b0;
    host_model_inst.wr16(16'h0013);
    clkEn = 1'b1;
    verify();
    $display("test frozen clock done");
    run("locked", '{16'h0020, 16'h0013, 16'h001B, 16'h001C, 16'h0041, 16'h0042, 16'h0043,
      16'h0044, 16'h0020, 16'h0011, 16'h000C, 16'h0023, 16'h0007, 16'h0000});
    doReset();
    // Power-off is tried before and after arming
    run("power off", '{16'h001C, 16'h001B, 16'h001C});
    for (int i = 0; i < 10; i++) issue({8'($random(seed)) | 8'h01, 8'($random(seed))});
    $display("test unknown codes done");
    complete_run();
  end
endmodule
`default_nettype wire
